// *** pmt_timer.sv ***
// What this block does
// - Every count-equals-period match drives a four-bit postscaler whose output feeds the interrupt logic.
// - The postscaler output sets the match interrupt flag, which stays set until software clears it.
// - The flag reaches the interrupt output only while the match interrupt enable bit is set.
// - Control bits 6 to 3 select a postscale ratio of the field value plus one.
// - The unscaled match pulse goes out as the PWM time base for the capture/compare/PWM units.
// - The match output is offered as a shift clock source for the serial port in SPI mode.
// - In sleep the timer neither counts nor raises match events.
// - In sleep the count and period registers keep their values.
// - Control bit 7 is unimplemented and reads as zero.
// - Control bit 2 turns the timer on; while off the count holds.
// - Control bits 1 to 0 pick a prescale of 1, 4, 16 or 64.
// - The timer input clock is the instruction clock, a quarter of the system clock, through the prescaler.
// - Count and period are compared each timer clock; on equality a match pulse issues and the count restarts at zero.
// - Reset clears the count and sets the period to all ones.
// - Writing the count or control register, or reset, clears prescaler and postscaler; a control write keeps the count.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pmt_timer
	import pmt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pmt_addr_width-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pmt_data_width-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pmt_addr_width-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pmt_data_width-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_mode,
	output logic ccp_time_base,
	output logic spi_shift_tick,
	output logic irq
);
	logic [7:0] timer_control;
	logic [7:0] period_value;
	logic [7:0] timer_count;
	logic match_irq_flag;
	logic match_irq_enable;
	logic [1:0] instr_phase;
	logic instr_tick;
	logic pre_fire;
	logic post_fire;
	logic match_evt;
	logic scaler_clear;
	logic [pmt_addr_width-1:0] aw_addr;
	logic aw_held;
	logic [7:0] w_byte;
	logic w_lane0;
	logic w_held;
	logic do_write;
	logic wr_ctl;
	logic wr_per;
	logic wr_cnt;
	logic wr_flg;
	logic wr_ena;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic timer_run;

	function automatic logic [pmt_pre_width-1:0] pre_limit(input logic [1:0] sel);
		logic [pmt_pre_width-1:0] lim;
		lim = pmt_pre_lim64;
		if (sel == pmt_pre_div1)
			lim = pmt_pre_lim1;
		else if (sel == pmt_pre_div4)
			lim = pmt_pre_lim4;
		else if (sel == pmt_pre_div16)
			lim = pmt_pre_lim16;
		return lim;
	endfunction

	// Instruction clock enable, one aclk in four
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			instr_phase <= 2'h0;
		end
		else
		begin
			instr_phase <= instr_phase + 2'h1;
		end
	end
	assign instr_tick = (instr_phase == 2'(pmt_osc_per_instr - 1));

	// Counting halts when off or asleep
	assign timer_run = instr_tick && timer_control[pmt_ctl_on_bit] && !sleep_mode;

	assign scaler_clear = wr_cnt || wr_ctl;

	pmt_divider #(
		.width(pmt_pre_width)
	) u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(scaler_clear),
		.tick(timer_run),
		.limit(pre_limit(timer_control[pmt_ctl_pre_msb:pmt_ctl_pre_lsb])),
		.fire(pre_fire)
	);

	// Compare on every timer clock
	assign match_evt = pre_fire && (timer_count == period_value) && !wr_cnt;

	pmt_divider #(
		.width(pmt_post_width)
	) u_postscaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(scaler_clear),
		.tick(match_evt),
		.limit(timer_control[pmt_ctl_post_msb:pmt_ctl_post_lsb]),
		.fire(post_fire)
	);

	// Count register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_count <= pmt_rst_timer_count;
		end
		else if (wr_cnt)
		begin
			timer_count <= w_byte;
		end
		else if (match_evt)
		begin
			timer_count <= 8'h00;
		end
		else if (pre_fire)
		begin
			timer_count <= timer_count + 8'h01;
		end
	end

	// Period register, software only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			period_value <= pmt_rst_period_value;
		end
		else if (wr_per)
		begin
			period_value <= w_byte;
		end
	end

	// Control register, bit 7 held at zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_control <= pmt_rst_timer_control;
		end
		else if (wr_ctl)
		begin
			timer_control <= w_byte & pmt_ctl_write_mask;
		end
	end

	// Sticky flag; a new event beats a write-one-to-clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			match_irq_flag <= 1'b0;
		end
		else if (post_fire)
		begin
			match_irq_flag <= 1'b1;
		end
		else if (wr_flg && w_byte[pmt_irq_match_bit])
		begin
			match_irq_flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			match_irq_enable <= 1'b0;
		end
		else if (wr_ena)
		begin
			match_irq_enable <= w_byte[pmt_irq_match_bit];
		end
	end

	// Outputs to the interrupt line, PWM units and serial port
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq <= 1'b0;
			ccp_time_base <= 1'b0;
			spi_shift_tick <= 1'b0;
		end
		else
		begin
			irq <= match_irq_flag && match_irq_enable;
			ccp_time_base <= match_evt;
			spi_shift_tick <= match_evt;
		end
	end

	// Write address channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			aw_held <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
		begin
			aw_held <= 1'b0;
		end
		else if (!aw_held && !s_axi_bvalid)
		begin
			s_axi_awready <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b0;
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			w_held <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
		end
		else if (do_write)
		begin
			w_held <= 1'b0;
		end
		else if (!w_held && !s_axi_bvalid)
		begin
			s_axi_wready <= 1'b1;
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Write decode; a cleared low-byte strobe leaves the register alone
	always_comb
	begin
		wr_ctl = 1'b0;
		wr_per = 1'b0;
		wr_cnt = 1'b0;
		wr_flg = 1'b0;
		wr_ena = 1'b0;
		wr_hit = 1'b1;
		if (aw_addr == pmt_off_timer_control)
			wr_ctl = do_write && w_lane0;
		else if (aw_addr == pmt_off_period_value)
			wr_per = do_write && w_lane0;
		else if (aw_addr == pmt_off_timer_count)
			wr_cnt = do_write && w_lane0;
		else if (aw_addr == pmt_off_peripheral_irq_flags)
			wr_flg = do_write && w_lane0;
		else if (aw_addr == pmt_off_peripheral_irq_enables)
			wr_ena = do_write && w_lane0;
		else
			wr_hit = 1'b0;
	end

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pmt_resp_okay;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? pmt_resp_okay : pmt_resp_slverr;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		if (s_axi_araddr == pmt_off_timer_control)
			rd_byte = timer_control & pmt_ctl_write_mask;
		else if (s_axi_araddr == pmt_off_period_value)
			rd_byte = period_value;
		else if (s_axi_araddr == pmt_off_timer_count)
			rd_byte = timer_count;
		else if (s_axi_araddr == pmt_off_peripheral_irq_flags)
			rd_byte = {7'h00, match_irq_flag};
		else if (s_axi_araddr == pmt_off_peripheral_irq_enables)
			rd_byte = {7'h00, match_irq_enable};
		else
			rd_hit = 1'b0;
	end

	// Read channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= pmt_resp_okay;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_hit ? pmt_resp_okay : pmt_resp_slverr;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
		else if (!s_axi_rvalid)
		begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule // pmt_timer

// *** pmt_pkg.sv ***
package pmt_pkg;
	localparam int unsigned pmt_data_width = 32;
	localparam int unsigned pmt_addr_width = 8;
	localparam logic [7:0] pmt_off_timer_control = 8'h00;
	localparam logic [7:0] pmt_off_period_value = 8'h04;
	localparam logic [7:0] pmt_off_timer_count = 8'h08;
	localparam logic [7:0] pmt_off_peripheral_irq_flags = 8'h0C;
	localparam logic [7:0] pmt_off_peripheral_irq_enables = 8'h10;
	localparam int unsigned pmt_ctl_unused_bit = 7;
	localparam int unsigned pmt_ctl_post_lsb = 3;
	localparam int unsigned pmt_ctl_post_msb = 6;
	localparam int unsigned pmt_ctl_on_bit = 2;
	localparam int unsigned pmt_ctl_pre_lsb = 0;
	localparam int unsigned pmt_ctl_pre_msb = 1;
	localparam int unsigned pmt_irq_match_bit = 0;
	localparam logic [7:0] pmt_rst_timer_control = 8'h00;
	localparam logic [7:0] pmt_rst_period_value = 8'hFF;
	localparam logic [7:0] pmt_rst_timer_count = 8'h00;
	localparam logic [7:0] pmt_ctl_write_mask = 8'h7F;
	localparam int unsigned pmt_osc_per_instr = 4;
	localparam int unsigned pmt_pre_width = 6;
	localparam int unsigned pmt_post_width = 4;
	localparam logic [1:0] pmt_pre_div1 = 2'h0;
	localparam logic [1:0] pmt_pre_div4 = 2'h1;
	localparam logic [1:0] pmt_pre_div16 = 2'h2;
	localparam logic [5:0] pmt_pre_lim1 = 6'h00;
	localparam logic [5:0] pmt_pre_lim4 = 6'h03;
	localparam logic [5:0] pmt_pre_lim16 = 6'h0F;
	localparam logic [5:0] pmt_pre_lim64 = 6'h3F;
	localparam logic [1:0] pmt_resp_okay = 2'h0;
	localparam logic [1:0] pmt_resp_slverr = 2'h2;
endpackage

// *** pmt_divider.sv ***
`timescale 1ns/10ps
module pmt_divider
	import pmt_pkg::*;
#(
	parameter int unsigned width = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic tick,
	input wire logic [width-1:0] limit,
	output logic fire
);
	logic [width-1:0] count;

	// Fires on the tick that completes limit plus one ticks
	assign fire = tick && (count >= limit);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
		begin
			count <= '0;
		end
		else if (fire)
		begin
			count <= '0;
		end
		else if (tick)
		begin
			count <= count + 1'b1;
		end
	end
endmodule // pmt_divider

// *** pmt_timer_properties.sv ***
`timescale 1ns/10ps
module pmt_timer_chk
	import pmt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sleep_mode,
	input wire logic ccp_time_base,
	input wire logic spi_shift_tick,
	input wire logic irq,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [pmt_data_width-1:0] s_axi_rdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_tick_copies_same: assert property (ccp_time_base == spi_shift_tick) else $error("tick copies differ");
	a_match_spacing: assert property (ccp_time_base |=> !ccp_time_base [*3]) else $error("match too soon");
	a_sleep_quiet: assert property (sleep_mode && $past(sleep_mode) |-> !ccp_time_base) else $error("match in sleep");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready in resp");
	cover property (ccp_time_base);
	cover property ($rose(irq));
	cover property (sleep_mode && s_axi_rvalid);
endmodule // pmt_timer_chk
bind pmt_timer pmt_timer_chk i_pmt_timer_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.sleep_mode(sleep_mode),
	.ccp_time_base(ccp_time_base),
	.spi_shift_tick(spi_shift_tick),
	.irq(irq),
	.s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata)
);

// *** pmt_far_end.sv ***
`timescale 1ns/10ps
module pmt_far_end
	import pmt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ccp_time_base,
	input wire logic spi_shift_tick,
	output logic [15:0] ticks
);
	// Counts time base pulses that the serial port also sees as shift ticks
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ticks <= 16'h0000;
		else if (ccp_time_base && spi_shift_tick)
			ticks <= ticks + 16'h0001;
	end
endmodule // pmt_far_end

// *** pmt_timer_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t %h %h", $time, g, e); end end
module pmt_timer_tb_top
	import pmt_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_mode;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ccp_time_base, spi_shift_tick, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, a;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [3:0] q;
	logic [15:0] ticks, t0;
	int bad_count = 0;
	int comparisons = 0;
	int seed = 78;
	int c;
	pmt_timer i_pmt_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.sleep_mode(sleep_mode),
		.ccp_time_base(ccp_time_base),
		.spi_shift_tick(spi_shift_tick),
		.irq(irq)
	);
	pmt_far_end i_pmt_far_end (
		.aclk(aclk),
		.aresetn(aresetn),
		.ccp_time_base(ccp_time_base),
		.spi_shift_tick(spi_shift_tick),
		.ticks(ticks)
	);
	function automatic int per(input logic [1:0] p, input logic [7:0] v);
		return 4 * (1 << (2 * p)) * (v + 1);
	endfunction
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic give_up();
		bad_count++;
		close_out();
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		int n;
		logic ha, hw, hb;
		n = 0;
		hb = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!hb && n < 50)
		begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'h0;
			if (hw) s_axi_wvalid <= 1'h0;
			n++;
		end
		s_axi_bready <= 1'h0;
		if (!hb) give_up();
	endtask
	task automatic rd(input logic [7:0] ad);
		int n;
		logic ha, hr;
		n = 0;
		hr = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!hr && n < 50)
		begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'h0;
			n++;
		end
		s_axi_rready <= 1'h0;
		if (!hr) give_up();
	endtask
	task automatic wp(output int k);
		k = 0;
		do @(negedge aclk) k++; while (!ccp_time_base && k < 5000);
		if (k >= 5000) give_up();
	endtask
	initial
	begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	initial
	begin
		aresetn = 1'h0;
		sleep_mode = 1'h0;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rd(pmt_off_timer_control);
		`CHK(d, 32'h00000000)
		rd(pmt_off_period_value);
		`CHK(d, 32'h000000FF)
		rd(pmt_off_timer_count);
		`CHK(d, 32'h00000000)
		rd(pmt_off_peripheral_irq_flags);
		`CHK(d, 32'h00000000)
		rd(8'h14);
		`CHK(r, pmt_resp_slverr)
		wr(8'h14, 32'h000000FF);
		`CHK(r, pmt_resp_slverr)
		wr(pmt_off_timer_count, 32'h00000055);
		repeat (40) @(posedge aclk);
		rd(pmt_off_timer_count);
		`CHK(d, 32'h00000055)
		s_axi_wstrb <= 4'hE;
		wr(pmt_off_timer_count, 32'h000000AA);
		s_axi_wstrb <= 4'hF;
		`CHK(r, pmt_resp_okay)
		rd(pmt_off_timer_count);
		`CHK(d, 32'h00000055)
		wr(pmt_off_timer_control, 32'h00000080);
		rd(pmt_off_timer_control);
		`CHK(d, 32'h00000000)
		rd(pmt_off_timer_count);
		`CHK(d, 32'h00000055)
		wr(pmt_off_timer_control, 32'h000000FF);
		rd(pmt_off_timer_control);
		`CHK(d, 32'h0000007F)
		for (int p = 0; p < 4; p++)
		begin
			pr = 8'($random(seed)) & 8'h03;
			wr(pmt_off_timer_control, 32'h00000000);
			wr(pmt_off_timer_count, 32'h00000000);
			wr(pmt_off_period_value, 32'(pr));
			wr(pmt_off_timer_control, 32'(p) | 32'h00000004);
			wp(c);
			wp(c);
			`CHK(c, per(2'(p), pr))
		end
		for (int i = 0; i < 3; i++)
		begin
			q = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
			wr(pmt_off_timer_control, 32'h00000000);
			wr(pmt_off_timer_count, 32'h00000000);
			wr(pmt_off_period_value, 32'h00000001);
			wr(pmt_off_peripheral_irq_flags, 32'h00000001);
			wr(pmt_off_peripheral_irq_enables, 32'h00000001);
			t0 = ticks;
			wr(pmt_off_timer_control, 32'({q, 3'h4}));
			c = 0;
			while (!irq && c < 20000)
			begin
				@(negedge aclk);
				c++;
			end
			if (c >= 20000) give_up();
			repeat (2) @(negedge aclk);
			`CHK(ticks - t0, 16'(q) + 16'h0001)
		end
		rd(pmt_off_peripheral_irq_enables);
		`CHK(d, 32'h00000001)
		wr(pmt_off_peripheral_irq_enables, 32'h00000000);
		repeat (3) @(negedge aclk);
		`CHK(irq, 1'h0)
		rd(pmt_off_peripheral_irq_flags);
		`CHK(d[0], 1'h1)
		wr(pmt_off_timer_control, 32'h00000000);
		wr(pmt_off_peripheral_irq_flags, 32'h00000001);
		rd(pmt_off_peripheral_irq_flags);
		`CHK(d, 32'h00000000)
		pr = 8'($random(seed)) & 8'h07;
		wr(pmt_off_timer_count, 32'h00000000);
		wr(pmt_off_period_value, 32'(pr));
		wr(pmt_off_timer_control, 32'h00000004);
		repeat (100) @(posedge aclk);
		sleep_mode <= 1'h1;
		rd(pmt_off_timer_count);
		a = d;
		repeat (60) @(posedge aclk);
		rd(pmt_off_timer_count);
		`CHK(d, a)
		rd(pmt_off_period_value);
		`CHK(d[7:0], pr)
		sleep_mode <= 1'h0;
		close_out();
	end
endmodule // pmt_timer_tb_top
